// File: common/nrsr_pkg.sv
// package: opcodes, field positions, widths and reset values for the nibble alu slice
package nrsr_pkg;
   // ----------------------------------------
   // instruction word layout
   // ----------------------------------------
   localparam int NRSR_IW_W = 16;           // instruction word width
   localparam int NRSR_ADDR_LSB = 0;        // ram address r6..r0
   localparam int NRSR_ADDR_W = 7;          // ram address width
   localparam int NRSR_WSEL_LSB = 0;        // working register select w3..w0
   localparam int NRSR_IMM_LSB = 4;         // immediate i3..i0
   localparam int NRSR_PC_W = 11;           // program counter width
   // ----------------------------------------
   // opcodes, left aligned in the word
   // ----------------------------------------
   localparam logic [8:0] NRSR_OP_ROTATE = 9'h09b;   // 0 1001 1011, 7-bit address follows
   localparam logic [8:0] NRSR_OP_SUB_MEM = 9'h014;  // 0 0001 0100
   localparam logic [8:0] NRSR_OP_SUBS_MEM = 9'h016; // 0 0001 0110
   localparam logic [7:0] NRSR_OP_SUB_IMM = 8'h0e;   // 0000 1110, imm and wr follow
   localparam logic [8:0] NRSR_OP_SUBS_IMM = 9'h01f; // 0 0001 1111
   localparam logic [13:0] NRSR_OP_RETURN = 14'h0080; // 00 0000 1000 0000
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [3:0] NRSR_ACC_RST = 4'h0;       // accumulator after reset
   localparam logic NRSR_FLAG_RST = 1'b0;            // flags after reset
   localparam logic [10:0] NRSR_PC_RST = 11'h000;    // pc after reset
endpackage

// File: rtl/nrsr_alu.sv
// combinational 4-bit subtract with borrow and flags
`timescale 1ns/1ns
module nrsr_alu
   import nrsr_pkg::*;
#(
   parameter int W = 4
) (
   // operands
   input wire logic [W-1:0] min_i,
   input wire logic [W-1:0] sub_i,
   input wire logic borrow_i,
   // result
   output logic [W-1:0] diff_o,
   output logic borrow_o,
   output logic zero_o
);
   logic [W:0] wide; // extra bit catches the borrow out of the top bit
   // plain subtract; a set top bit means the result wrapped below zero
   always_comb begin
      wide = {1'b0, min_i} - {1'b0, sub_i} - {{W{1'b0}}, borrow_i};
      diff_o = wide[W-1:0];
      borrow_o = wide[W];           // carry set means borrow occurred
      zero_o = (wide[W-1:0] == '0);
   end
endmodule // nrsr_alu

// File: rtl/nrsr_core.sv
// execution slice: rotate right through carry, subtract with borrow forms, return
`timescale 1ns/1ns
module nrsr_core
   import nrsr_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // instruction issue, one per cycle when valid
   input wire logic exec_i,
   input wire logic [NRSR_IW_W-1:0] instr_i,
   // data ram read port (combinational, addressed by ram_addr_o)
   input wire logic [3:0] ram_rdata_i,
   // working register read data for wr_sel_o
   input wire logic [3:0] wr_rdata_i,
   // top stack entry
   input wire logic [NRSR_PC_W-1:0] stack_top_i,
   // addresses presented to the ram and working registers
   output logic [NRSR_ADDR_W-1:0] ram_addr_o,
   output logic [3:0] wr_sel_o,
   // write back strobes, pulses
   output logic ram_we_o,
   output logic wr_we_o,
   output logic [3:0] wdata_o,
   // stack pop and pc load, pulses
   output logic stack_pop_o,
   output logic pc_load_o,
   output logic [NRSR_PC_W-1:0] pc_o,
   // architectural state
   output logic [3:0] acc_o,
   output logic carry_flag_o,
   output logic zero_flag_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] acc;              // accumulator
      logic carry;                  // carry flag
      logic zero;                   // zero flag
      logic [NRSR_PC_W-1:0] pc;     // last loaded pc
      logic pc_ld;                  // pc load pulse
      logic ram_we;                 // ram write pulse
      logic wr_we;                  // wr write pulse
      logic [3:0] wdata;            // write back value
      logic [NRSR_ADDR_W-1:0] waddr; // held address for the write
      logic [3:0] wsel;             // held wr select
   } nrsr_state_t;

   nrsr_state_t st_reg;
   nrsr_state_t st_next;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic is_rot, is_subm, is_subsm, is_subi, is_subsi, is_ret;
   logic [3:0] imm;
   logic [3:0] rot_val;
   logic [3:0] diff;
   logic bout, dzero;
   logic use_imm;

   always_comb begin
      is_rot = exec_i && (instr_i[15:7] == NRSR_OP_ROTATE);
      is_subm = exec_i && (instr_i[15:7] == NRSR_OP_SUB_MEM);
      is_subsm = exec_i && (instr_i[15:7] == NRSR_OP_SUBS_MEM);
      is_subi = exec_i && (instr_i[15:8] == NRSR_OP_SUB_IMM);
      // store immediate form differs from sub_imm in bit 8; its bit 7 doubles as i3, so i3 is 1
      is_subsi = exec_i && (instr_i[15:7] == NRSR_OP_SUBS_IMM);
      is_ret = exec_i && (instr_i[15:2] == NRSR_OP_RETURN);
      // plain immediate form must not shadow the store form
      if (is_subsi) begin
         is_subi = 1'b0;
      end
      use_imm = is_subi || is_subsi;
      imm = instr_i[NRSR_IMM_LSB +: 4];
      // old carry into bit 3, bit 0 leaves as new carry
      rot_val = {st_reg.carry, ram_rdata_i[3:1]};
   end

   assign ram_addr_o = instr_i[NRSR_ADDR_LSB +: NRSR_ADDR_W];
   assign wr_sel_o = instr_i[NRSR_WSEL_LSB +: 4];

   // shared subtractor: memory forms subtract acc, immediate forms subtract i
   nrsr_alu #(
      .W(4)
   ) nrsr_alu_i (
      .min_i(use_imm ? wr_rdata_i : ram_rdata_i),
      .sub_i(use_imm ? imm : st_reg.acc),
      .borrow_i(st_reg.carry),
      .diff_o(diff),
      .borrow_o(bout),
      .zero_o(dzero)
   );

   // ----------------------------------------
   // next state, all in one cycle
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.pc_ld = 1'b0;         // strobes fall unless refired
      st_next.ram_we = 1'b0;
      st_next.wr_we = 1'b0;
      if (is_rot) begin
         st_next.acc = rot_val;
         st_next.carry = ram_rdata_i[0];
         st_next.zero = (rot_val == 4'h0);
         st_next.wdata = rot_val;
         st_next.waddr = ram_addr_o;
         st_next.ram_we = 1'b1;
      end else if (is_subm || is_subsm || is_subi || is_subsi) begin
         st_next.acc = diff;
         st_next.carry = bout;
         st_next.zero = dzero;
         st_next.wdata = diff;
         st_next.waddr = ram_addr_o;
         st_next.wsel = wr_sel_o;
         st_next.ram_we = is_subsm;
         st_next.wr_we = is_subsi;
      end else if (is_ret) begin
         st_next.pc = stack_top_i;
         st_next.pc_ld = 1'b1;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
         st_reg.acc <= NRSR_ACC_RST;
         st_reg.carry <= NRSR_FLAG_RST;
         st_reg.zero <= NRSR_FLAG_RST;
         st_reg.pc <= NRSR_PC_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // stack pop is combinational so the stack pointer moves with the pc load
   // hazard: a user that registers the pop as well would pop one cycle late
   assign stack_pop_o = is_ret;
   assign pc_load_o = st_reg.pc_ld;
   assign pc_o = st_reg.pc;
   assign ram_we_o = st_reg.ram_we;
   assign wr_we_o = st_reg.wr_we;
   assign wdata_o = st_reg.wdata;
   assign acc_o = st_reg.acc;
   assign carry_flag_o = st_reg.carry;
   assign zero_flag_o = st_reg.zero;

   // ----------------------------------------
   // checks: rotate and return
   // ----------------------------------------
   // rotate: the old carry enters at the top and bit 0 leaves as carry
   rot_result_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_rot |=> acc_o == {$past(st_reg.carry), $past(ram_rdata_i[3:1])}
                 && carry_flag_o == $past(ram_rdata_i[0]))
      else $error("rotate result wrong");
   // rotate writes the same nibble to ram and acc, never to a working register
   rot_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_rot |=> ram_we_o && wdata_o == acc_o && !wr_we_o)
      else $error("rotate write back wrong");
   // return: the popped entry lands in the pc one cycle later
   ret_pc_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_ret |=> pc_load_o && pc_o == $past(stack_top_i))
      else $error("return pc wrong");
   // a return leaves the alu side alone; only the pc moves
   ret_quiet_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_ret |=> !ram_we_o && !wr_we_o && $stable(acc_o) && $stable(carry_flag_o)
                 && $stable(zero_flag_o))
      else $error("return disturbed alu state");
   // the pc is only ever loaded by a return
   pc_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !is_ret |=> !pc_load_o && $stable(pc_o))
      else $error("pc moved without return");
   // ----------------------------------------
   // checks: subtract forms
   // ----------------------------------------
   // plain memory form loads only the accumulator
   sub_mem_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_subm |=> !ram_we_o && !wr_we_o && acc_o == 4'($past(ram_rdata_i)
                  - $past(st_reg.acc) - {3'h0, $past(st_reg.carry)}))
      else $error("memory subtract wrong");
   // plain immediate form loads only the accumulator
   sub_imm_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_subi |=> !ram_we_o && !wr_we_o && acc_o == 4'($past(wr_rdata_i)
                  - $past(imm) - {3'h0, $past(st_reg.carry)}))
      else $error("immediate subtract wrong");
   // store memory form: the write goes to the address of the issue cycle
   subs_mem_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_subsm |=> ram_we_o && wdata_o == acc_o && st_reg.waddr == $past(ram_addr_o))
      else $error("memory store subtract wrong");
   // store memory form carries the same difference as the plain form
   subs_mem_val_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_subsm |=> !wr_we_o && acc_o == 4'($past(ram_rdata_i)
                   - $past(st_reg.acc) - {3'h0, $past(st_reg.carry)}))
      else $error("memory store subtract value wrong");
   // store immediate form writes the selected working register
   subs_imm_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      is_subsi |=> wr_we_o && !ram_we_o && wdata_o == acc_o
                   && st_reg.wsel == $past(wr_sel_o))
      else $error("wr store subtract wrong");
   // ----------------------------------------
   // checks: flags
   // ----------------------------------------
   // zero follows the nibble that landed in the accumulator
   zero_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (is_rot || is_subm || is_subsm || is_subi || is_subsi)
      |=> zero_flag_o == (acc_o == 4'h0))
      else $error("zero flag wrong");
   // carry set means the subtrahend plus old carry exceeded the minuend;
   // worked out by comparison rather than by subtraction, so a slip in the alu shows up
   mem_borrow_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (is_subm || is_subsm)
      |=> carry_flag_o == (({1'b0, $past(st_reg.acc)} + {4'h0, $past(st_reg.carry)})
                           > {1'b0, $past(ram_rdata_i)}))
      else $error("memory borrow wrong");
   // same polarity for the immediate forms, with the immediate as subtrahend
   imm_borrow_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (is_subi || is_subsi)
      |=> carry_flag_o == (({1'b0, $past(imm)} + {4'h0, $past(st_reg.carry)})
                           > {1'b0, $past(wr_rdata_i)}))
      else $error("immediate borrow wrong");
endmodule // nrsr_core

// File: sim/nrsr_mem_model.sv
// partner model: data ram nibbles and working registers beside the slice
`timescale 1ns/1ns
module nrsr_mem_model
   import nrsr_pkg::*;
(
   // clock
   input wire logic mclk_i,
   // addresses presented by the slice
   input wire logic [NRSR_ADDR_W-1:0] addr_i,
   input wire logic [3:0] sel_i,
   // write back from the slice
   input wire logic ram_we_i,
   input wire logic wr_we_i,
   input wire logic [3:0] wdata_i,
   // read data, combinational
   output logic [3:0] ram_rdata_o,
   output logic [3:0] wr_rdata_o
);
   logic [3:0] ram [0:127]; // data nibbles, preloaded by the bench
   logic [3:0] wr [0:15]; // working registers
   logic [NRSR_ADDR_W-1:0] addr_reg; // address of the issue cycle
   logic [3:0] sel_reg; // select of the issue cycle
   assign ram_rdata_o = ram[addr_i];
   assign wr_rdata_o = wr[sel_i];
   // strobes arrive a cycle late, when the address lines already show the next word
   always @(posedge mclk_i) begin
      addr_reg <= addr_i;
      sel_reg <= sel_i;
      if (ram_we_i) ram[addr_reg] <= wdata_i;
      if (wr_we_i) wr[sel_reg] <= wdata_i;
   end
endmodule // nrsr_mem_model

// File: sim/nrsr_core_tb.sv
// self-checking bench for the nibble execution slice
`timescale 1ns/1ns
module nrsr_core_tb
   import nrsr_pkg::*;
;
   // design ports, expected state and tallies
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic exec_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic [10:0] stack_top_i = 11'h000;
   logic [10:0] pc_o;
   logic [6:0] ram_addr_o;
   logic [3:0] ram_rdata_i, wr_rdata_i, wr_sel_o, wdata_o, acc_o, acc_e;
   logic ram_we_o, wr_we_o, stack_pop_o, pc_load_o, carry_flag_o, zero_flag_o, c_e;
   int errors = 0;
   int compares = 0;
   always #5 mclk_i = ~mclk_i; // 100 MHz
   nrsr_core nrsr_core_i (.mclk_i, .rstn_i, .exec_i, .instr_i, .ram_rdata_i, .wr_rdata_i,
      .stack_top_i, .ram_addr_o, .wr_sel_o, .ram_we_o, .wr_we_o, .wdata_o, .stack_pop_o,
      .pc_load_o, .pc_o, .acc_o, .carry_flag_o, .zero_flag_o);
   nrsr_mem_model nrsr_mem_model_i (.mclk_i, .addr_i(ram_addr_o), .sel_i(wr_sel_o),
      .ram_we_i(ram_we_o), .wr_we_i(wr_we_o), .wdata_i(wdata_o),
      .ram_rdata_o(ram_rdata_i), .wr_rdata_o(wr_rdata_i));
   // compare with case equality so an unknown never matches
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // verdict, the only exit
   task automatic tally_and_finish();
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // borrow lands in bit 4, difference below
   function automatic logic [4:0] sbb(input logic [3:0] a, input logic [3:0] b, input logic c);
      return {1'b0, a} - {1'b0, b} - {4'h0, c};
   endfunction
   // hold one word across one edge; caller decides whether exec stays up
   task automatic issue(input logic [15:0] iw);
      exec_i = 1'b1;
      instr_i = iw;
      @(posedge mclk_i);
      #1;
   endtask
   // judge results one cycle after issue, then track them
   task automatic expect_out(input logic [4:0] r, input logic rwe, input logic wwe);
      check("acc", acc_o, r[3:0]);
      check("flags", {carry_flag_o, zero_flag_o}, {r[4], r[3:0] == 4'h0});
      check("strobes", {ram_we_o, wr_we_o}, {rwe, wwe});
      if (rwe | wwe) check("wdata", wdata_o, r[3:0]);
      {c_e, acc_e} = r;
   endtask
   // one instruction, then an idle cycle so the write back lands
   task automatic run(input logic [15:0] iw, input logic [4:0] r, input logic rwe, input logic wwe);
      issue(iw);
      exec_i = 1'b0;
      expect_out(r, rwe, wwe);
      @(posedge mclk_i);
      #1;
   endtask
   // rotate at both address extremes, first result zero
   task automatic t_rotate();
      logic [3:0] d [4] = '{4'h1, 4'hb, 4'h0, 4'h6};
      logic [6:0] a;
      for (int k = 0; k < 4; k++) begin
         a = k[0] ? 7'h7f : 7'h00;
         nrsr_mem_model_i.ram[a] = d[k];
         run({NRSR_OP_ROTATE, a}, {d[k][0], c_e, d[k][3:1]}, 1'b1, 1'b0);
         check("ram", nrsr_mem_model_i.ram[a], acc_e);
      end
   endtask
   // memory minus acc minus carry, memory left alone
   task automatic t_sub_mem();
      logic [3:0] d [4] = '{4'h0, 4'hf, 4'h8, 4'h7};
      for (int k = 0; k < 4; k++) begin
         nrsr_mem_model_i.ram[7'h05] = d[k];
         run({NRSR_OP_SUB_MEM, 7'h05}, sbb(d[k], acc_e, c_e), 1'b0, 1'b0);
         check("ram", nrsr_mem_model_i.ram[7'h05], d[k]);
      end
   endtask
   // immediate forms, plain then store; the store immediate has its top bit set
   task automatic t_sub_imm();
      logic [3:0] i [2] = '{4'h8, 4'hf};
      logic [3:0] w;
      for (int k = 0; k < 2; k++) begin
         w = k[0] ? 4'hf : 4'h0;
         nrsr_mem_model_i.wr[4'hc] = 4'h9;
         run({NRSR_OP_SUB_IMM, i[k], 4'hc}, sbb(4'h9, i[k], c_e), 1'b0, 1'b0);
         check("wr", nrsr_mem_model_i.wr[4'hc], 4'h9);
         nrsr_mem_model_i.wr[w] = 4'h9;
         run({NRSR_OP_SUBS_IMM, i[k][2:0], w}, sbb(4'h9, i[k], c_e), 1'b0, 1'b1);
         check("wr", nrsr_mem_model_i.wr[w], acc_e);
      end
   endtask
   // return: pop in the issue cycle, pc loaded once and then held
   task automatic t_return();
      logic [10:0] t [2] = '{11'h7ff, 11'h401};
      for (int k = 0; k < 2; k++) begin
         stack_top_i = t[k];
         exec_i = 1'b1;
         instr_i = {NRSR_OP_RETURN, k[0], k[0]};
         #1;
         check("pop", stack_pop_o, 1'b1);
         @(posedge mclk_i);
         #1;
         exec_i = 1'b0;
         stack_top_i = ~t[k];
         check("pc", {pc_load_o, pc_o, acc_o}, {1'b1, t[k], acc_e});
         @(posedge mclk_i);
         #1;
         check("pc", {pc_load_o, pc_o}, {1'b0, t[k]});
         check("pop", stack_pop_o, 1'b0);
      end
   endtask
   // back to back stores, second sees the first result; then an unknown word
   task automatic t_back();
      logic [4:0] e;
      nrsr_mem_model_i.ram[7'h11] = 4'h5;
      nrsr_mem_model_i.ram[7'h22] = 4'h0;
      issue({NRSR_OP_SUBS_MEM, 7'h11});
      e = sbb(4'h5, acc_e, c_e);
      expect_out(e, 1'b1, 1'b0);
      issue({NRSR_OP_SUBS_MEM, 7'h22});
      exec_i = 1'b0;
      expect_out(sbb(4'h0, acc_e, c_e), 1'b1, 1'b0);
      @(posedge mclk_i);
      #1;
      check("ram", {nrsr_mem_model_i.ram[7'h11], nrsr_mem_model_i.ram[7'h22]}, {e[3:0], acc_e});
      run(16'hffff, {c_e, acc_e}, 1'b0, 1'b0);
   endtask
   // main sequence: preload, reset for five cycles, scenarios
   initial begin
      for (int k = 0; k < 128; k++) nrsr_mem_model_i.ram[k] = k[3:0];
      for (int k = 0; k < 16; k++) nrsr_mem_model_i.wr[k] = k[3:0];
      repeat (5) @(posedge mclk_i);
      #1;
      rstn_i = 1'b1;
      check("reset", {acc_o, carry_flag_o, zero_flag_o},
         {NRSR_ACC_RST, NRSR_FLAG_RST, NRSR_FLAG_RST});
      check("reset pc", {pc_load_o, pc_o}, {1'b0, NRSR_PC_RST});
      check("reset strobes", {ram_we_o, wr_we_o}, 2'b00);
      {c_e, acc_e} = {NRSR_FLAG_RST, NRSR_ACC_RST};
      t_rotate();
      t_sub_mem();
      t_sub_imm();
      t_return();
      t_back();
      tally_and_finish();
   end
   // hang guard: a bounded count of edges
   initial begin
      repeat (2000) @(posedge mclk_i);
      errors++;
      tally_and_finish();
   end
endmodule // nrsr_core_tb
